//--- common/ssof_defs.svh
`ifndef SSOF_DEFS_SVH
`define SSOF_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SSOF_OFS_CTRL     8'h00
`define SSOF_OFS_TARGET_SPEED_REACHED     8'h04
`define SSOF_OFS_ZERO_SPEED_FLAG     8'h08
`define SSOF_OFS_PWIN     8'h0C
`define SSOF_OFS_TQLO     8'h10
`define SSOF_OFS_TQHI     8'h14
`define SSOF_OFS_OVLD     8'h18
`define SSOF_OFS_DLY      8'h1C
`define SSOF_OFS_POL      8'h20
`define SSOF_OFS_FLAGS    8'h24
`define SSOF_OFS_IRQ_STAT 8'h28
`define SSOF_OFS_IRQ_MASK 8'h2C
// ----------------------------------------
// reset values
// ----------------------------------------
`define SSOF_RST_ZERO_SPEED_FLAG 16'h000A
`define SSOF_RST_PWIN 16'h0063
`define SSOF_RST_TARGET_SPEED_REACHED 16'h0BB8
`define SSOF_RST_TQ   16'h0064
`define SSOF_RST_OVLD 16'h0078
`define SSOF_RST_DLY  16'h0000
// ----------------------------------------
// control register fields
// ----------------------------------------
`define SSOF_CTRL_MODE_LSB 0
`define SSOF_CTRL_TQSRC    2
`define SSOF_CTRL_SHARE    3
// ----------------------------------------
// flag vector bit positions
// ----------------------------------------
`define SSOF_F_RDY  0
`define SSOF_F_ZERO_SPEED_FLAG 1
`define SSOF_F_TARGET_SPEED_REACHED 2
`define SSOF_F_POSITION_IN_BAND 3
`define SSOF_F_TQL  4
`define SSOF_F_FAULT_ALARM 5
`define SSOF_F_BRK  6
`define SSOF_F_HOME 7
`define SSOF_F_OLW  8
`define SSOF_F_WARN 9
`define SSOF_F_CMD  10
`define SSOF_NFLAGS 11
// ----------------------------------------
// timing: one unit of the completion delay
// ----------------------------------------
`define SSOF_DLY_UNIT_US 1
`define SSOF_CLK_MHZ 250
`endif

//--- common/ssof_pkg.sv
`default_nettype none
package ssof_pkg;
    // control mode of the drive
    typedef enum logic [1:0] {
        SSOF_MODE_PT = 2'h0,
        SSOF_MODE_PR = 2'h1,
        SSOF_MODE_SPD = 2'h2,
        SSOF_MODE_TRQ = 2'h3
    } ssof_mode_t;
    // completion delay states, one-hot
    typedef enum logic [2:0] {
        SSOF_D_IDLE = 3'h1,
        SSOF_D_WAIT = 3'h2,
        SSOF_D_DONE = 3'h4
    } ssof_dly_t;
endpackage
`default_nettype wire

//--- logic/ssof_hyst.sv
`default_nettype none
`include "ssof_defs.svh"
// comparator with hold: sets on set_i, clears on clr_i
module ssof_hyst
    import ssof_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    logic q_ff; // held state
    logic nxt_q;
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        nxt_q = q_ff;
        if (set_i)
            nxt_q = 1'b1;
        else if (clr_i)
            nxt_q = 1'b0;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_ff <= 1'b0;
        else
            q_ff <= nxt_q;
    end
    assign q_o = q_ff;
endmodule
`default_nettype wire

//--- logic/ssof_sync.sv
`default_nettype none
`include "ssof_defs.svh"
// three-flop synchroniser; a change counts when stages two and three agree
module ssof_sync
    import ssof_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic [2:0] st_ff; // shift stages
    logic q_ff; // filtered level
    logic [2:0] nxt_st;
    logic nxt_q;
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st = {st_ff[1:0], d_i};
        nxt_q = q_ff;
        // stage 0 is only read by stage 1
        if (st_ff[1] == st_ff[2])
            nxt_q = st_ff[2];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= 3'h0;
            q_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            q_ff <= nxt_q;
        end
    end
    assign q_o = q_ff;
endmodule
`default_nettype wire

//--- logic/ssof_top.sv
// Function
// - target speed flag set at setting, held; here it clears as soon as speed drops below the setting
// - pulse mode: error within window
// - register mode: position within plus-minus window
// - torque limit from settings or analog
// - alarm on any fault, warning-class one cycle after warning
// - warning-class faults raise warning first
// - homing done after sensor and conditions
// - overload flag at programmed level
// - move done after programmed delay
// - per-output polarity setting
// - shared pin: target speed or homing
// - shared pin: brake or position band
// - brake output while brake actuated
// - ready only with no fault present
// - zero speed flag at or below setting
//
// Chosen here: the Wishbone slave port and the address map.
`default_nettype none
`include "ssof_defs.svh"
module ssof_top
    import ssof_pkg::*;
#(
    parameter int DW = 16,
    parameter int NF = `SSOF_NFLAGS
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // drive state, same clock
    input wire logic [DW-1:0] speed_i,
    input wire logic signed [31:0] pos_err_i,
    input wire logic [DW-1:0] torque_i,
    input wire logic [DW-1:0] torque_ext_lim_i,
    input wire logic [DW-1:0] load_i,
    input wire logic servo_ok_i,
    input wire logic fault_i,
    input wire logic [4:0] warn_fault_i,
    input wire logic brake_act_i,
    input wire logic home_cond_ok_i,
    input wire logic move_end_i,
    // pin from outside
    input wire logic home_sensor_i,
    // output terminals
    output logic [NF-1:0] flag_o,
    output logic pin_shared_a_o,
    output logic pin_shared_b_o
);
    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [3:0] ctrl_ff; // mode, torque source, share select
    logic [DW-1:0] target_speed_reached_ff, zero_speed_flag_ff, pwin_ff, tqlo_ff, tqhi_ff;
    logic [DW-1:0] ovld_ff, dly_ff;
    logic [NF-1:0] pol_ff, stat_ff, mask_ff;
    logic ack_ff;
    logic [31:0] rd_ff;
    logic [3:0] nxt_ctrl;
    logic [DW-1:0] nxt_target_speed_reached, nxt_zero_speed_flag, nxt_pwin, nxt_tqlo, nxt_tqhi;
    logic [DW-1:0] nxt_ovld, nxt_dly;
    logic [NF-1:0] nxt_pol, nxt_stat, nxt_mask;
    logic nxt_ack;
    logic [31:0] nxt_rd;
    logic wr, req;
    logic [NF-1:0] flags_ff, prev_ff; // raw flags, last cycle
    logic [NF-1:0] nxt_flags;
    ssof_mode_t mode;
    assign mode = ssof_mode_t'(ctrl_ff[`SSOF_CTRL_MODE_LSB +: 2]);
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i & wb_sel_i[0];

    // bus decode and write; one wait state, ack a cycle after request
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_target_speed_reached = target_speed_reached_ff;
        nxt_zero_speed_flag = zero_speed_flag_ff;
        nxt_pwin = pwin_ff;
        nxt_tqlo = tqlo_ff;
        nxt_tqhi = tqhi_ff;
        nxt_ovld = ovld_ff;
        nxt_dly = dly_ff;
        nxt_pol = pol_ff;
        nxt_mask = mask_ff;
        nxt_ack = req;
        nxt_rd = 32'h0;
        // events: rising flag edges; set wins over write-one clear
        nxt_stat = stat_ff;
        if (wr && wb_adr_i == `SSOF_OFS_IRQ_STAT)
            nxt_stat = stat_ff & ~wb_dat_i[NF-1:0];
        nxt_stat = nxt_stat | (flags_ff & ~prev_ff);
        if (wr)
        begin
            case (wb_adr_i)
                `SSOF_OFS_CTRL: nxt_ctrl = wb_dat_i[3:0];
                `SSOF_OFS_TARGET_SPEED_REACHED: nxt_target_speed_reached = wb_dat_i[DW-1:0];
                `SSOF_OFS_ZERO_SPEED_FLAG: nxt_zero_speed_flag = wb_dat_i[DW-1:0];
                `SSOF_OFS_PWIN: nxt_pwin = wb_dat_i[DW-1:0];
                `SSOF_OFS_TQLO: nxt_tqlo = wb_dat_i[DW-1:0];
                `SSOF_OFS_TQHI: nxt_tqhi = wb_dat_i[DW-1:0];
                `SSOF_OFS_OVLD: nxt_ovld = wb_dat_i[DW-1:0];
                `SSOF_OFS_DLY: nxt_dly = wb_dat_i[DW-1:0];
                `SSOF_OFS_POL: nxt_pol = wb_dat_i[NF-1:0];
                `SSOF_OFS_IRQ_MASK: nxt_mask = wb_dat_i[NF-1:0];
                default: nxt_ctrl = ctrl_ff; // unmapped: ignored
            endcase
        end
        // reads; unmapped reads return zero
        case (wb_adr_i)
            `SSOF_OFS_CTRL: nxt_rd[3:0] = ctrl_ff;
            `SSOF_OFS_TARGET_SPEED_REACHED: nxt_rd[DW-1:0] = target_speed_reached_ff;
            `SSOF_OFS_ZERO_SPEED_FLAG: nxt_rd[DW-1:0] = zero_speed_flag_ff;
            `SSOF_OFS_PWIN: nxt_rd[DW-1:0] = pwin_ff;
            `SSOF_OFS_TQLO: nxt_rd[DW-1:0] = tqlo_ff;
            `SSOF_OFS_TQHI: nxt_rd[DW-1:0] = tqhi_ff;
            `SSOF_OFS_OVLD: nxt_rd[DW-1:0] = ovld_ff;
            `SSOF_OFS_DLY: nxt_rd[DW-1:0] = dly_ff;
            `SSOF_OFS_POL: nxt_rd[NF-1:0] = pol_ff;
            `SSOF_OFS_FLAGS: nxt_rd[NF-1:0] = flags_ff;
            `SSOF_OFS_IRQ_STAT: nxt_rd[NF-1:0] = stat_ff;
            `SSOF_OFS_IRQ_MASK: nxt_rd[NF-1:0] = mask_ff;
            default: nxt_rd = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= 4'h0;
            target_speed_reached_ff <= `SSOF_RST_TARGET_SPEED_REACHED;
            zero_speed_flag_ff <= `SSOF_RST_ZERO_SPEED_FLAG;
            pwin_ff <= `SSOF_RST_PWIN;
            tqlo_ff <= `SSOF_RST_TQ;
            tqhi_ff <= `SSOF_RST_TQ;
            ovld_ff <= `SSOF_RST_OVLD;
            dly_ff <= `SSOF_RST_DLY;
            pol_ff <= '0;
            stat_ff <= '0;
            mask_ff <= '0;
            ack_ff <= 1'b0;
            rd_ff <= 32'h0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            target_speed_reached_ff <= nxt_target_speed_reached;
            zero_speed_flag_ff <= nxt_zero_speed_flag;
            pwin_ff <= nxt_pwin;
            tqlo_ff <= nxt_tqlo;
            tqhi_ff <= nxt_tqhi;
            ovld_ff <= nxt_ovld;
            dly_ff <= nxt_dly;
            pol_ff <= nxt_pol;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_ff;
    assign irq_o = |(stat_ff & mask_ff);

    // ----------------------------------------
    // hysteresis comparators and home sensor synchroniser
    // ----------------------------------------
    logic target_speed_reached_q, zero_speed_flag_q, home_s;
    // set at setting, clear below it
    ssof_hyst u_target_speed_reached (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(speed_i >= target_speed_reached_ff),
        .clr_i(speed_i < target_speed_reached_ff),
        .q_o(target_speed_reached_q)
    );
    // set at or below range, clear above it
    ssof_hyst u_zero_speed_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(speed_i <= zero_speed_flag_ff),
        .clr_i(speed_i > zero_speed_flag_ff),
        .q_o(zero_speed_flag_q)
    );
    ssof_sync u_home (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(home_sensor_i),
        .q_o(home_s)
    );

    // ----------------------------------------
    // completion delay for move done
    // ----------------------------------------
    localparam int UNIT = `SSOF_DLY_UNIT_US * `SSOF_CLK_MHZ;
    ssof_dly_t dst_ff, nxt_dst;
    logic [31:0] dcnt_ff, nxt_dcnt;
    always_comb
    begin
        nxt_dst = dst_ff;
        nxt_dcnt = dcnt_ff;
        unique case (dst_ff)
            SSOF_D_IDLE:
            begin
                nxt_dcnt = 32'(dly_ff) * 32'(UNIT);
                if (move_end_i)
                    nxt_dst = (nxt_dcnt == 32'h0) ? SSOF_D_DONE : SSOF_D_WAIT;
            end
            SSOF_D_WAIT:
            begin
                if (!move_end_i)
                    nxt_dst = SSOF_D_IDLE;
                else if (dcnt_ff <= 32'h1)
                    nxt_dst = SSOF_D_DONE;
                else
                    nxt_dcnt = dcnt_ff - 32'h1;
            end
            SSOF_D_DONE:
                if (!move_end_i)
                    nxt_dst = SSOF_D_IDLE;
            default: nxt_dst = SSOF_D_IDLE;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dst_ff <= SSOF_D_IDLE;
            dcnt_ff <= 32'h0;
        end
        else
        begin
            dst_ff <= nxt_dst;
            dcnt_ff <= nxt_dcnt;
        end
    end

    // ----------------------------------------
    // flag evaluation, registered each cycle
    // ----------------------------------------
    logic [31:0] err_abs;
    logic [DW-1:0] tq_lim;
    logic any_fault, any_warn;
    assign err_abs = pos_err_i[31] ? 32'(-pos_err_i) : 32'(pos_err_i);
    // limit from settings or external analog source
    assign tq_lim = ctrl_ff[`SSOF_CTRL_TQSRC] ? torque_ext_lim_i
                  : ((torque_i[DW-1]) ? tqlo_ff : tqhi_ff);
    assign any_warn = |warn_fault_i;
    assign any_fault = fault_i | any_warn;
    always_comb
    begin
        nxt_flags = '0;
        nxt_flags[`SSOF_F_RDY] = servo_ok_i & ~any_fault;
        nxt_flags[`SSOF_F_ZERO_SPEED_FLAG] = zero_speed_flag_q;
        nxt_flags[`SSOF_F_TARGET_SPEED_REACHED] = target_speed_reached_q;
        // same band check on magnitude of error
        if (mode == SSOF_MODE_PT || mode == SSOF_MODE_PR)
            nxt_flags[`SSOF_F_POSITION_IN_BAND] = err_abs <= 32'(pwin_ff);
        nxt_flags[`SSOF_F_TQL] = torque_i >= tq_lim;
        // warning-class faults show warning first, alarm a cycle later
        nxt_flags[`SSOF_F_WARN] = any_warn;
        nxt_flags[`SSOF_F_FAULT_ALARM] = fault_i
            | (any_warn & flags_ff[`SSOF_F_WARN]);
        nxt_flags[`SSOF_F_BRK] = brake_act_i;
        nxt_flags[`SSOF_F_HOME] = home_s & home_cond_ok_i;
        nxt_flags[`SSOF_F_OLW] = load_i >= ovld_ff;
        nxt_flags[`SSOF_F_CMD] = dst_ff == SSOF_D_DONE;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_ff <= '0;
            prev_ff <= '0;
        end
        else
        begin
            flags_ff <= nxt_flags;
            prev_ff <= flags_ff;
        end
    end

    // output stage: polarity and shared terminals, registered
    logic [NF-1:0] out_ff, nxt_out;
    logic sha_ff, shb_ff, nxt_sha, nxt_shb;
    always_comb
    begin
        nxt_out = flags_ff ^ pol_ff;
        // position modes (PT, PR) route homing / position, others speed / brake
        if (mode == SSOF_MODE_PT || mode == SSOF_MODE_PR)
        begin
            nxt_sha = nxt_out[`SSOF_F_HOME];
            nxt_shb = nxt_out[`SSOF_F_POSITION_IN_BAND];
        end
        else
        begin
            nxt_sha = nxt_out[`SSOF_F_TARGET_SPEED_REACHED];
            nxt_shb = nxt_out[`SSOF_F_BRK];
        end
        if (ctrl_ff[`SSOF_CTRL_SHARE])
            nxt_sha = nxt_out[`SSOF_F_TARGET_SPEED_REACHED];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_ff <= '0;
            sha_ff <= 1'b0;
            shb_ff <= 1'b0;
        end
        else
        begin
            out_ff <= nxt_out;
            sha_ff <= nxt_sha;
            shb_ff <= nxt_shb;
        end
    end
    assign flag_o = out_ff;
    assign pin_shared_a_o = sha_ff;
    assign pin_shared_b_o = shb_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    target_speed_reached_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (speed_i >= target_speed_reached_ff) |=> ##1 flags_ff[`SSOF_F_TARGET_SPEED_REACHED])
        else $error("target speed flag missed");
    zero_speed_flag_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (speed_i > zero_speed_flag_ff) |=> ##1 !flags_ff[`SSOF_F_ZERO_SPEED_FLAG])
        else $error("zero speed flag held above range");
    ready_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
        any_fault |=> !flags_ff[`SSOF_F_RDY])
        else $error("ready with fault");
    warn_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(flags_ff[`SSOF_F_FAULT_ALARM]) && !$past(fault_i)
            |-> $past(flags_ff[`SSOF_F_WARN]))
        else $error("alarm before warning");
    alarm_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fault_i |=> flags_ff[`SSOF_F_FAULT_ALARM])
        else $error("alarm missed");
    move_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (dst_ff == SSOF_D_IDLE && move_end_i && dly_ff != '0)
            |=> !flags_ff[`SSOF_F_CMD] ##1 !flags_ff[`SSOF_F_CMD])
        else $error("move done too early");
    polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> flag_o == ($past(flags_ff) ^ $past(pol_ff)))
        else $error("polarity wrong");
    home_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !home_cond_ok_i |=> !flags_ff[`SSOF_F_HOME])
        else $error("home without conditions");
    pos_band_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == SSOF_MODE_PT && err_abs > 32'(pwin_ff))
            |=> !flags_ff[`SSOF_F_POSITION_IN_BAND])
        else $error("position band wrong");
endmodule
`default_nettype wire

//--- verification/ssof_reader.sv
`default_nettype none
// ----------------------------------------
// machine controller reading the alarm terminal
// ----------------------------------------
module ssof_reader
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic alarm_i,
    output logic [7:0] alarm_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic alarm_ff; // last sampled level
    // counts alarm assertions, as a controller log would
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            alarm_ff <= 1'b0;
            alarm_cnt_o <= 8'h00;
        end
        else
        begin
            alarm_ff <= alarm_i;
            if (alarm_i && !alarm_ff)
                alarm_cnt_o <= alarm_cnt_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- verification/ssof_top_bench.sv
`default_nettype none
`include "ssof_defs.svh"
module ssof_top_bench;
    import ssof_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq, pa, pb;
    logic [15:0] spd = 16'h0, trq = 16'h0, tlim = 16'h0, load = 16'h0;
    logic signed [31:0] perr = 32'sh0;
    logic ok = 1'b0, flt = 1'b0, brk = 1'b0, hok = 1'b0, mend = 1'b0;
    logic hsen = 1'b0;
    logic [4:0] wflt = 5'h00;
    logic [10:0] fl;
    logic [7:0] acnt;
    int miscompares = 0, comparisons = 0;
    logic [31:0] got;
    always #2 clk_i = ~clk_i; // 250 MHz
    ssof_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .speed_i(spd), .pos_err_i(perr), .torque_i(trq),
        .torque_ext_lim_i(tlim), .load_i(load), .servo_ok_i(ok),
        .fault_i(flt), .warn_fault_i(wflt), .brake_act_i(brk),
        .home_cond_ok_i(hok), .move_end_i(mend),
        .home_sensor_i(hsen), .flag_o(fl), .pin_shared_a_o(pa),
        .pin_shared_b_o(pb));
    ssof_reader ctl (.clk_i(clk_i), .rst_i(rst_i),
        .alarm_i(fl[`SSOF_F_FAULT_ALARM]), .alarm_cnt_o(acnt));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one classic cycle; request held until ack is sampled high at an edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        // no answer time assumed; only the watchdog ends a hang
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        got = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // speed flags pass the hold stage: pins follow within three edges
    task automatic settle();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] ofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
            8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C, 8'h3C};
        logic [31:0] val [11] = '{0, 32'h0BB8, 32'h000A, 32'h0063,
            32'h0064, 32'h0064, 32'h0078, 0, 0, 0, 0};
        for (int i = 0; i < 11; i++)
        begin
            bus(1'b0, ofs[i], 32'h0);
            chk(got, val[i]);
        end
        done("reset");
    endtask
    task automatic t_speed();
        logic [15:0] s [4] = '{16'h000A, 16'h000B, 16'h0BB8, 16'h0BB7};
        logic [3:0] z = 4'b0001, t = 4'b0100;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_i);
            spd <= s[i];
            settle();
            chk(fl[`SSOF_F_ZERO_SPEED_FLAG], z[i]);
            chk(fl[`SSOF_F_TARGET_SPEED_REACHED], t[i]);
        end
        done("speed");
    endtask
    task automatic t_pos();
        logic signed [31:0] e [4] = '{99, 100, -99, -100};
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, `SSOF_OFS_CTRL, m);
            for (int i = 0; i < 4; i++)
            begin
                @(posedge clk_i);
                perr <= e[i];
                settle();
                chk(fl[`SSOF_F_POSITION_IN_BAND], i % 2 == 0);
                chk(pb, i % 2 == 0);
            end
        end
        done("position");
    endtask
    task automatic t_torque();
        @(posedge clk_i);
        trq <= 16'h0063;
        settle();
        chk(fl[`SSOF_F_TQL], 0);
        @(posedge clk_i);
        trq <= 16'h0064;
        settle();
        chk(fl[`SSOF_F_TQL], 1);
        bus(1'b1, `SSOF_OFS_CTRL, 32'h4);
        @(posedge clk_i);
        tlim <= 16'h0070;
        settle();
        chk(fl[`SSOF_F_TQL], 0);
        @(posedge clk_i);
        trq <= 16'h0070;
        settle();
        chk(fl[`SSOF_F_TQL], 1);
        done("torque");
    endtask
    task automatic t_fault();
        int n;
        @(posedge clk_i);
        ok <= 1'b1;
        settle();
        chk(fl[`SSOF_F_RDY], 1);
        @(posedge clk_i);
        flt <= 1'b1;
        settle();
        chk({fl[`SSOF_F_FAULT_ALARM], fl[`SSOF_F_RDY]}, 2'b10);
        @(posedge clk_i);
        flt <= 1'b0;
        settle();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_i);
            wflt <= 5'h01 << i;
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end
            while (fl[`SSOF_F_WARN] !== 1'b1 && n < 10);
            chk(fl[`SSOF_F_WARN], 1);
            chk(fl[`SSOF_F_FAULT_ALARM], 0);
            @(negedge clk_i);
            chk(fl[`SSOF_F_FAULT_ALARM], 1);
            @(posedge clk_i);
            wflt <= 5'h00;
            settle();
        end
        chk(acnt, 8'h06);
        done("fault");
    endtask
    task automatic t_home();
        bus(1'b1, `SSOF_OFS_CTRL, 32'h0);
        @(posedge clk_i);
        hsen <= 1'b1;
        repeat (8) @(negedge clk_i);
        chk({fl[`SSOF_F_HOME], pa}, 2'b00);
        @(posedge clk_i);
        hok <= 1'b1;
        settle();
        chk({fl[`SSOF_F_HOME], pa}, 2'b11);
        // share select forces terminal a back to target speed, now low
        bus(1'b1, `SSOF_OFS_CTRL, 32'h8);
        settle();
        chk({fl[`SSOF_F_HOME], pa}, 2'b10);
        @(posedge clk_i);
        hsen <= 1'b0;
        repeat (8) @(negedge clk_i);
        chk(fl[`SSOF_F_HOME], 0);
        done("home");
    endtask
    task automatic t_shared();
        bus(1'b1, `SSOF_OFS_CTRL, 32'h2);
        @(posedge clk_i);
        spd <= 16'h0BB8;
        brk <= 1'b1;
        settle();
        chk({pa, pb, fl[`SSOF_F_BRK]}, 3'b111);
        @(posedge clk_i);
        spd <= 16'h0000;
        brk <= 1'b0;
        settle();
        chk({pa, pb, fl[`SSOF_F_BRK]}, 3'b000);
        done("shared");
    endtask
    task automatic t_load_pol();
        bus(1'b1, `SSOF_OFS_POL, 32'h1 << `SSOF_F_OLW);
        settle();
        chk(fl[`SSOF_F_OLW], 1);
        @(posedge clk_i);
        load <= 16'h0078;
        settle();
        chk(fl[`SSOF_F_OLW], 0);
        bus(1'b0, `SSOF_OFS_FLAGS, 32'h0);
        chk(got[`SSOF_F_OLW], 1);
        bus(1'b1, `SSOF_OFS_POL, 32'h0);
        @(posedge clk_i);
        load <= 16'h0077;
        settle();
        chk(fl[`SSOF_F_OLW], 0);
        done("overload");
    endtask
    task automatic t_move();
        bus(1'b1, `SSOF_OFS_DLY, 32'h2);
        @(posedge clk_i);
        mend <= 1'b1;
        repeat (450) @(negedge clk_i);
        chk(fl[`SSOF_F_CMD], 0);
        repeat (100) @(negedge clk_i);
        chk(fl[`SSOF_F_CMD], 1);
        @(posedge clk_i);
        mend <= 1'b0;
        settle();
        chk(fl[`SSOF_F_CMD], 0);
        done("move");
    endtask
    task automatic t_irq();
        // earlier tests left sticky bits; clear them so the rise is real
        bus(1'b1, `SSOF_OFS_IRQ_STAT, 32'h7FF);
        bus(1'b1, `SSOF_OFS_IRQ_MASK, 32'h1 << `SSOF_F_TARGET_SPEED_REACHED);
        @(negedge clk_i);
        chk(irq, 0);
        @(posedge clk_i);
        spd <= 16'h0BB8;
        settle();
        @(negedge clk_i);
        chk(irq, 1);
        bus(1'b1, `SSOF_OFS_IRQ_STAT, 32'h1 << `SSOF_F_TARGET_SPEED_REACHED);
        settle();
        chk(irq, 0);
        bus(1'b1, `SSOF_OFS_IRQ_MASK, 32'h0);
        @(posedge clk_i);
        spd <= 16'h0000;
        settle();
        @(posedge clk_i);
        spd <= 16'h0BB8;
        settle();
        chk(irq, 0);
        bus(1'b0, `SSOF_OFS_IRQ_STAT, 32'h0);
        chk(got[`SSOF_F_TARGET_SPEED_REACHED], 1);
        done("interrupt");
    endtask
    // ----------------------------------------
    // closing and main sequence
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // whole run is under a thousand cycles; this is ample
    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_speed();
        t_pos();
        t_torque();
        t_fault();
        t_home();
        t_shared();
        t_load_pol();
        t_move();
        t_irq();
        conclude();
    end
endmodule
`default_nettype wire
